//--- core/dat_lru.sv
// Purpose: Eight-by-eight least-recently-used matrix for the translation buffer.
// Assumes: Touch is a single-cycle strobe; clear is a level held while the table-reset bit is set.
// Notes: The selected entry is the lowest one whose row is all clear.
`timescale 1ns/1ps
`default_nettype none
module dat_lru #(
  parameter int N = 8,
  parameter int IDX_W = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_touch,
  input wire logic [IDX_W-1:0] i_idx,
  output logic [IDX_W-1:0] o_sel
);
  logic [N-1:0] row [N];

  // A touch sets the entry's row and clears its column.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int r = 0; r < N; r++) begin
        row[r] <= '0;
      end
    end else if (i_clr) begin
      for (int r = 0; r < N; r++) begin
        row[r] <= '0;
      end
    end else if (i_touch) begin
      for (int r = 0; r < N; r++) begin
        for (int c = 0; c < N; c++) begin
          if (c == int'(i_idx)) begin
            row[r][c] <= 1'h0;
          end else if (r == int'(i_idx)) begin
            row[r][c] <= 1'h1;
          end
        end
      end
    end
  end

  // The least recently used entry has an all-clear row.
  always_comb begin
    o_sel = '0;
    for (int r = N - 1; r >= 0; r--) begin
      if (row[r] == '0) begin
        o_sel = IDX_W'(r);
      end
    end
  end

  AST_LRU_MOVES: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_touch && !i_clr |=> o_sel != $past(i_idx))
    else $error("LRU still points at the entry just used.");
endmodule
`default_nettype wire

//--- core/dat_pkg.sv
// Purpose: Shared constants and types for the address translation buffer.
// Assumes: Bit 0 of a printed field is the most significant bit of its word.
// Notes: Exception codes are the program-interruption codes, in hex.
package dat_pkg;
  // Buffer geometry.
  localparam int TLB_ENTRIES = 8;
  localparam int IDX_W = 3;
  localparam int TAG_W = 16;
  localparam int REAL_W = 16;
  // Legal segment-size and page-size control bytes.
  localparam logic [7:0] FMT_64K_2K = 8'h40;
  localparam logic [7:0] FMT_64K_4K = 8'h80;
  localparam logic [7:0] FMT_1M_2K = 8'h50;
  localparam logic [7:0] FMT_1M_4K = 8'h90;
  localparam int FMT_1M_BIT = 4;
  localparam int FMT_4K_BIT = 7;
  localparam logic [7:0] SEG_LEN_1M = 8'h00;
  // Program-interruption codes.
  localparam logic [7:0] EXC_SEG = 8'h10;
  localparam logic [7:0] EXC_PAGE = 8'h11;
  localparam logic [7:0] EXC_SPEC = 8'h12;
  // Translation control latch: value after reset and bit positions.
  localparam logic [7:0] CTL_RESET_VAL = 8'h00;
  localparam int CTL_ON = 7;
  localparam int CTL_ADJ = 6;
  localparam int CTL_EMU = 3;
  localparam int CTL_TBL_RST = 0;
  // Segment table entry fields.
  localparam int SEG_INV_BIT = 0;
  localparam int PTO_HI = 23;
  localparam int PTO_LO = 3;
  localparam int PTL_HI = 31;
  localparam int PTL_LO = 28;
  // Page table entry masks for 4k and 2k pages.
  localparam logic [15:0] PTE4K_ADDR = 16'hFFF0;
  localparam logic [15:0] PTE4K_INV = 16'h0008;
  localparam logic [15:0] PTE4K_FMT = 16'h0006;
  localparam logic [15:0] PTE2K_ADDR = 16'hFFF8;
  localparam logic [15:0] PTE2K_INV = 16'h0004;
  localparam logic [15:0] PTE2K_FMT = 16'h0002;
  // Recording block is 2048 bytes.
  localparam int BLK_LSB = 11;
  // Lookup sequencer states.
  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_READ = 2'b10
  } dat_lk_state_t;
endpackage

//--- core/dat_store.sv
// Purpose: Entry storage of the translation buffer with a registered read port.
// Assumes: Write is a single-cycle strobe and clear a level held while set, both in the i_clk domain.
// Notes: Parity is kept with each entry but never checked.
`timescale 1ns/1ps
`default_nettype none
module dat_store #(
  parameter int ENTRIES = 8,
  parameter int IDX_W = 3,
  parameter int TAG_W = 16,
  parameter int REAL_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_wr,
  input wire logic [IDX_W-1:0] i_wr_idx,
  input wire logic [TAG_W-1:0] i_wr_tag,
  input wire logic [REAL_W-1:0] i_wr_real,
  input wire logic [IDX_W-1:0] i_rd_idx,
  output logic [ENTRIES*TAG_W-1:0] o_tag,
  output logic [ENTRIES-1:0] o_valid,
  output logic [REAL_W-1:0] o_rd_real
);
  logic [TAG_W-1:0] tag_mem [ENTRIES];
  logic [REAL_W-1:0] real_mem [ENTRIES];
  logic [ENTRIES-1:0] par_mem;

  // Clear wipes every bit of every entry, parity included; clear beats a write.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= '0;
      par_mem <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        tag_mem[i] <= '0;
        real_mem[i] <= '0;
      end
    end else if (i_clr) begin
      o_valid <= '0;
      par_mem <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        tag_mem[i] <= '0;
        real_mem[i] <= '0;
      end
    end else if (i_wr) begin
      tag_mem[i_wr_idx] <= i_wr_tag;
      real_mem[i_wr_idx] <= i_wr_real;
      par_mem[i_wr_idx] <= ~^{i_wr_tag, i_wr_real};
      o_valid[i_wr_idx] <= 1'h1;
    end
  end

  // Real page of the addressed entry, one cycle after the index.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_real <= '0;
    end else begin
      o_rd_real <= real_mem[i_rd_idx];
    end
  end

  // All tags are presented in parallel for the match compare.
  for (genvar g = 0; g < ENTRIES; g++) begin : g_tag
    assign o_tag[g*TAG_W +: TAG_W] = tag_mem[g];
  end
endmodule
`default_nettype wire

//--- core/dat_tlb.sv
// Purpose: Dynamic translation checks, key recording and the translation buffer.
// Assumes: All inputs but i_arst_n are synchronous to i_clk; strobes last one cycle.
// Notes: The microprogram walks the tables; this block checks and caches.
// Behaviour
// - Segment entry invalid bit set raises code 10, else translation goes on.
// - Page table origin is segment bits 8-28 with three zero bits appended.
// - Page entry is two bytes; high bits 0-11 or 0-12 give the real page.
// - Page entry invalid bit 12 or 13 set raises code 11.
// - Page entry bits 13 and 14, or bit 14, nonzero raises code 12.
// - Emulated address plus adjustment is translated; tag keeps the unadjusted address.
// - Only control bytes 40, 80, 50, 90 are legal; others raise code 12.
// - Segment number beyond length code, counted in sixteens, raises code 10.
// - 1M segments allow only length code 00; 64k accepts any length code, 00 to FF.
// - Key bit 5 records a reference on every read or store.
// - Key bit 6 records a change on every store; bits 0-4 untouched.
// - Recording works on 2048-byte blocks in every mode, translation on or off.
// - Eight entries, virtual page in high bytes, real page in low bytes.
// - Tag is address byte 1 with byte 2 bits 0-3 or 0-4.
// - Table destination writes real and virtual address into the LRU entry.
// - While table-reset bit 7 is set, all entries clear fully, parity included.
// - Every tag is compared; a hit routes real page plus displacement out.
// - A hit clears the entry's matrix column and sets its row.
// - Matrix selects only for table writes; microprogram may also touch it.
// - Resetting the entries also resets the matrix.
// - Entries are valid with either parity; no parity error is raised.
// - Page number beyond the segment's page table length raises code 11.
`timescale 1ns/1ps
`default_nettype none
module dat_tlb #(
  parameter int ENTRIES = dat_pkg::TLB_ENTRIES,
  parameter bit RECORDING_ON = 1'h1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ctl_wr,
  input wire logic [15:0] i_inbound_data_bus,
  input wire logic i_fmt_chk,
  input wire logic [7:0] i_fmt_byte,
  input wire logic [7:0] i_seg_len,
  input wire logic i_seg_chk,
  input wire logic [31:0] i_seg_entry,
  input wire logic i_pte_chk,
  input wire logic i_table_dest,
  input wire logic i_xlate_req,
  input wire logic [23:0] i_virtual_address_register,
  input wire logic [23:0] i_adj_factor,
  input wire logic i_lru_touch,
  input wire logic [2:0] i_lru_idx,
  input wire logic i_stor_acc,
  input wire logic i_stor_write,
  input wire logic [23:0] i_stor_addr,
  output logic [7:0] o_translation_control_latch,
  output logic o_table_reset,
  output logic o_fmt_1m,
  output logic o_fmt_4k,
  output logic o_exc,
  output logic [7:0] o_exc_code,
  output logic [23:0] o_pto,
  output logic [23:0] o_pte_addr,
  output logic o_xlate_done,
  output logic o_hit,
  output logic o_miss,
  output logic [23:0] o_sar,
  output logic o_key_upd,
  output logic [12:0] o_key_blk,
  output logic o_key_ref,
  output logic o_key_chg
);
  logic rst_meta;
  logic rst_n;
  logic [7:0] ctl;
  logic seg_1m;
  logic pg4k;
  logic [7:0] seg_len;
  logic [23:0] va_eff;
  logic [23:0] va_hold;
  logic pend_hit;
  logic pend_xl;
  dat_pkg::dat_lk_state_t lk_state;
  logic lk_accept;
  logic [15:0] req_tag;
  logic [ENTRIES*16-1:0] tags;
  logic [ENTRIES-1:0] valid;
  logic [ENTRIES-1:0] hit_vec;
  logic hit_any;
  logic [2:0] hit_idx;
  logic [2:0] lru_sel;
  logic lru_touch;
  logic [2:0] lru_idx;
  logic [15:0] rd_real;
  logic [15:0] wr_real;
  logic fmt_bad;
  logic seg_oob;
  logic pg_oob;
  logic [3:0] pg_hi;
  logic [8:0] pg_idx;
  logic pte_inv;
  logic pte_fmt_bad;

  // Release of the asynchronous reset through two flip-flops.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n <= rst_meta;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  // Virtual tag: byte 1 plus byte 2 bits 0-3 (4k) or 0-4 (2k).
  function automatic logic [15:0] tag_of(input logic [23:0] va, input logic is4k);
    tag_of = is4k ? {va[23:12], 4'h0} : {va[23:11], 3'h0};
  endfunction

  // Control-byte legality for the four segment and page size pairs.
  function automatic logic fmt_ok(input logic [7:0] b);
    fmt_ok = (b == dat_pkg::FMT_64K_2K) || (b == dat_pkg::FMT_64K_4K) ||
             (b == dat_pkg::FMT_1M_2K) || (b == dat_pkg::FMT_1M_4K);
  endfunction

  // Translation control latch loaded from the inbound bus.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= dat_pkg::CTL_RESET_VAL;
    end else if (i_ctl_wr) begin
      ctl <= i_inbound_data_bus[7:0];
    end
  end
  assign o_translation_control_latch = ctl;
  assign o_table_reset = ctl[dat_pkg::CTL_TBL_RST];

  // Format check; only a legal byte updates the stored sizes.
  assign fmt_bad = !fmt_ok(i_fmt_byte) ||
                   (i_fmt_byte[dat_pkg::FMT_1M_BIT] && i_seg_len != dat_pkg::SEG_LEN_1M);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_1m <= 1'h0;
      pg4k <= 1'h0;
      seg_len <= 8'h00;
    end else if (i_fmt_chk && !fmt_bad) begin
      seg_1m <= i_fmt_byte[dat_pkg::FMT_1M_BIT];
      pg4k <= i_fmt_byte[dat_pkg::FMT_4K_BIT];
      seg_len <= i_seg_len;
    end
  end
  assign o_fmt_1m = seg_1m;
  assign o_fmt_4k = pg4k;

  // Emulated addresses get the adjustment before translation.
  assign va_eff = (ctl[dat_pkg::CTL_ADJ] && ctl[dat_pkg::CTL_EMU]) ?
                  i_virtual_address_register + i_adj_factor : i_virtual_address_register;

  // Parallel tag compare against the unadjusted address.
  assign req_tag = tag_of(i_virtual_address_register, pg4k);
  for (genvar g = 0; g < ENTRIES; g++) begin : g_match
    assign hit_vec[g] = valid[g] && (tags[g*16 +: 16] == req_tag);
  end
  assign hit_any = |hit_vec;
  always_comb begin
    hit_idx = 3'h0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = 3'(i);
      end
    end
  end

  // Lookup sequencer: take the request, then answer one cycle later.
  assign lk_accept = (lk_state == dat_pkg::LK_IDLE) && i_xlate_req;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_state <= dat_pkg::LK_IDLE;
      pend_hit <= 1'h0;
      pend_xl <= 1'h0;
      va_hold <= 24'h000000;
    end else begin
      case (lk_state)
        dat_pkg::LK_IDLE: begin
          if (i_xlate_req) begin
            lk_state <= dat_pkg::LK_READ;
            pend_xl <= ctl[dat_pkg::CTL_ON];
            pend_hit <= !ctl[dat_pkg::CTL_ON] || hit_any;
            va_hold <= va_eff;
          end
        end
        dat_pkg::LK_READ: begin
          lk_state <= dat_pkg::LK_IDLE;
        end
        default: begin
          lk_state <= dat_pkg::LK_IDLE;
        end
      endcase
    end
  end

  // Answer: real page with displacement, or a miss for the table walk.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_xlate_done <= 1'h0;
      o_hit <= 1'h0;
      o_miss <= 1'h0;
      o_sar <= 24'h000000;
    end else begin
      o_xlate_done <= lk_state == dat_pkg::LK_READ;
      o_hit <= (lk_state == dat_pkg::LK_READ) && pend_hit;
      o_miss <= (lk_state == dat_pkg::LK_READ) && !pend_hit;
      if (lk_state == dat_pkg::LK_READ) begin
        if (!pend_xl) begin
          o_sar <= va_hold;
        end else if (pg4k) begin
          o_sar <= {rd_real[15:4], va_hold[11:0]};
        end else begin
          o_sar <= {rd_real[15:3], va_hold[10:0]};
        end
      end
    end
  end

  // Matrix touch: a hit first, then a table write, then the microprogram.
  assign lru_touch = (lk_accept && ctl[dat_pkg::CTL_ON] && hit_any) || i_table_dest || i_lru_touch;
  assign lru_idx = (lk_accept && ctl[dat_pkg::CTL_ON] && hit_any) ? hit_idx :
                   i_table_dest ? lru_sel : i_lru_idx;

  // Real page from the page entry, masked by page size.
  assign wr_real = i_inbound_data_bus & (pg4k ? dat_pkg::PTE4K_ADDR : dat_pkg::PTE2K_ADDR);

  dat_store #(
    .ENTRIES(ENTRIES),
    .IDX_W(3),
    .TAG_W(16),
    .REAL_W(16)
  ) u_store (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clr(ctl[dat_pkg::CTL_TBL_RST]),
    .i_wr(i_table_dest),
    .i_wr_idx(lru_sel),
    .i_wr_tag(tag_of(i_virtual_address_register, pg4k)),
    .i_wr_real(wr_real),
    .i_rd_idx(hit_idx),
    .o_tag(tags),
    .o_valid(valid),
    .o_rd_real(rd_real)
  );

  dat_lru #(
    .N(ENTRIES),
    .IDX_W(3)
  ) u_lru (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clr(ctl[dat_pkg::CTL_TBL_RST]),
    .i_touch(lru_touch),
    .i_idx(lru_idx),
    .o_sel(lru_sel)
  );

  // Range checks against the address held from the last request.
  assign seg_oob = !seg_1m && ({4'h0, va_hold[23:20]} > seg_len);
  assign pg_hi = seg_1m ? va_hold[19:16] : va_hold[15:12];
  assign pg_oob = pg_hi > i_seg_entry[dat_pkg::PTL_HI:dat_pkg::PTL_LO];
  assign pg_idx = seg_1m ? (pg4k ? {1'h0, va_hold[19:12]} : va_hold[19:11]) :
                  (pg4k ? {5'h00, va_hold[15:12]} : {4'h0, va_hold[15:11]});

  // Page entry invalid and format bits by page size.
  assign pte_inv = |(i_inbound_data_bus & (pg4k ? dat_pkg::PTE4K_INV : dat_pkg::PTE2K_INV));
  assign pte_fmt_bad = |(i_inbound_data_bus & (pg4k ? dat_pkg::PTE4K_FMT : dat_pkg::PTE2K_FMT));

  // Exception reporting; a format fault outranks an invalid page.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_exc <= 1'h0;
      o_exc_code <= 8'h00;
    end else begin
      o_exc <= 1'h0;
      if (i_fmt_chk && fmt_bad) begin
        o_exc <= 1'h1;
        o_exc_code <= dat_pkg::EXC_SPEC;
      end else if (i_seg_chk && (i_seg_entry[dat_pkg::SEG_INV_BIT] || seg_oob)) begin
        o_exc <= 1'h1;
        o_exc_code <= dat_pkg::EXC_SEG;
      end else if (i_seg_chk && pg_oob) begin
        o_exc <= 1'h1;
        o_exc_code <= dat_pkg::EXC_PAGE;
      end else if (i_pte_chk && pte_fmt_bad) begin
        o_exc <= 1'h1;
        o_exc_code <= dat_pkg::EXC_SPEC;
      end else if (i_pte_chk && pte_inv) begin
        o_exc <= 1'h1;
        o_exc_code <= dat_pkg::EXC_PAGE;
      end
    end
  end

  // Page table origin and the page entry address for the walk.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pto <= 24'h000000;
      o_pte_addr <= 24'h000000;
    end else if (i_seg_chk) begin
      o_pto <= {i_seg_entry[dat_pkg::PTO_HI:dat_pkg::PTO_LO], 3'h0};
      o_pte_addr <= {i_seg_entry[dat_pkg::PTO_HI:dat_pkg::PTO_LO], 3'h0} + {14'h0000, pg_idx, 1'h0};
    end
  end

  // Reference and change recording per 2048-byte block, in every mode.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_key_upd <= 1'h0;
      o_key_blk <= 13'h0000;
      o_key_ref <= 1'h0;
      o_key_chg <= 1'h0;
    end else begin
      o_key_upd <= RECORDING_ON && i_stor_acc;
      o_key_ref <= RECORDING_ON && i_stor_acc;
      o_key_chg <= RECORDING_ON && i_stor_acc && i_stor_write;
      if (i_stor_acc) begin
        o_key_blk <= i_stor_addr[23:dat_pkg::BLK_LSB];
      end
    end
  end

  AST_SEG_INVALID: assert property (i_seg_chk && !(i_fmt_chk && fmt_bad) && i_seg_entry[0]
    |=> o_exc && o_exc_code == 8'h10)
    else $error("Invalid segment entry did not raise code 10.");
  AST_PTO_FORM: assert property (i_seg_chk |=> o_pto[2:0] == 3'h0 &&
    o_pto[23:3] == $past(i_seg_entry[23:3]))
    else $error("Page table origin not formed from segment bits.");
  AST_PAGE_INVALID: assert property (i_pte_chk && !i_seg_chk && !i_fmt_chk && pte_inv &&
    !pte_fmt_bad |=> o_exc && o_exc_code == 8'h11)
    else $error("Invalid page entry did not raise code 11.");
  AST_FMT_BAD: assert property (i_fmt_chk && !fmt_ok(i_fmt_byte)
    |=> o_exc && o_exc_code == 8'h12)
    else $error("Illegal control byte did not raise code 12.");
  AST_REF_CHG: assert property (i_stor_acc |=> o_key_upd && o_key_ref &&
    o_key_chg == $past(i_stor_write) && o_key_blk == $past(i_stor_addr[23:11]))
    else $error("Key recording wrong for the accessed block.");
  AST_RESET_CLEARS: assert property (ctl[0] |=> valid == '0)
    else $error("Table reset left an entry valid.");
  AST_HIT_ANSWER: assert property (lk_accept && ctl[7] && hit_any
    |-> ##2 o_xlate_done && o_hit && !o_miss)
    else $error("Hit was not answered two cycles after the request.");
  AST_MISS_ANSWER: assert property (lk_accept && ctl[7] && !hit_any
    |=> !o_xlate_done ##1 o_xlate_done && o_miss)
    else $error("Miss was not reported two cycles after the request.");
  AST_SEG_RANGE: assert property (i_seg_chk && !i_fmt_chk && seg_oob
    |=> o_exc && o_exc_code == 8'h10)
    else $error("Segment number beyond length did not raise code 10.");
endmodule
`default_nettype wire

//--- verification/dat_mprog.sv
// Purpose: Microprogram model that raises the translation block's request lines.
// Assumes: Requests change only at the falling clock edge and last one cycle.
// Notes: Each request is at least two cycles from the next, as the block needs.
`timescale 1ns/1ps
`default_nettype none
module dat_mprog (
  input wire logic i_clk,
  output var logic o_ctl_wr,
  output var logic [15:0] o_bus,
  output var logic o_fmt_chk,
  output var logic [7:0] o_fmt_byte,
  output var logic [7:0] o_seg_len,
  output var logic o_seg_chk,
  output var logic [31:0] o_seg_entry,
  output var logic o_pte_chk,
  output var logic o_table_dest,
  output var logic o_xlate_req,
  output var logic [23:0] o_va,
  output var logic o_stor_acc,
  output var logic o_stor_write,
  output var logic [23:0] o_stor_addr
);
  logic [7:0] lat = 8'h00;
  // All request lines start quiet so nothing is taken during reset.
  initial begin
    o_ctl_wr = 1'h0;
    o_bus = 16'h0000;
    o_fmt_chk = 1'h0;
    o_fmt_byte = 8'h00;
    o_seg_len = 8'h00;
    o_seg_chk = 1'h0;
    o_seg_entry = 32'h00000000;
    o_pte_chk = 1'h0;
    o_table_dest = 1'h0;
    o_xlate_req = 1'h0;
    o_va = 24'h000000;
    o_stor_acc = 1'h0;
    o_stor_write = 1'h0;
    o_stor_addr = 24'h000000;
  end
  // Raises one strobe for one cycle; data was set at the edge before.
  task automatic fire(ref logic s);
    @(negedge i_clk);
    s = 1'h1;
    @(negedge i_clk);
    s = 1'h0;
  endtask
  // Writes the control latch from the low byte of the bus.
  task automatic ctl(input logic [7:0] v);
    lat = v;
    o_bus = {8'h00, v};
    fire(o_ctl_wr);
  endtask
  // Table reset is set by an OR word and later dropped by an AND word.
  task automatic reset_on();
    ctl(lat | 8'h01);
  endtask
  task automatic reset_off();
    ctl(lat & 8'hFE);
  endtask
  task automatic fmt(input logic [7:0] b, input logic [7:0] l);
    o_fmt_byte = b;
    o_seg_len = l;
    fire(o_fmt_chk);
  endtask
  task automatic seg(input logic [31:0] e);
    o_seg_entry = e;
    fire(o_seg_chk);
  endtask
  task automatic pte(input logic [15:0] w);
    o_bus = w;
    fire(o_pte_chk);
  endtask
  task automatic dest(input logic [23:0] va, input logic [15:0] w);
    o_va = va;
    o_bus = w;
    fire(o_table_dest);
  endtask
  task automatic xlate(input logic [23:0] va);
    o_va = va;
    fire(o_xlate_req);
  endtask
  task automatic acc(input logic [23:0] a, input logic w);
    o_stor_addr = a;
    o_stor_write = w;
    fire(o_stor_acc);
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Purpose: Self-checking bench for the translation checks, key recording and buffer.
// Assumes: The microprogram model raises requests; this bench watches the answers.
// Notes: The bench itself drives the adjustment factor and the microprogram matrix touch.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] FMTS [4] = '{dat_pkg::FMT_64K_2K, dat_pkg::FMT_64K_4K, dat_pkg::FMT_1M_2K, dat_pkg::FMT_1M_4K};
  localparam logic [7:0] BADF [3] = '{8'h33, 8'h00, 8'hC0};
  localparam logic [15:0] PTES [6] = '{16'h1238, 16'h1232, 16'h1230, 16'h1234, 16'h1232, 16'h1230};
  localparam logic [7:0] PEXC [6] = '{dat_pkg::EXC_PAGE, dat_pkg::EXC_SPEC, 8'h00, dat_pkg::EXC_PAGE, dat_pkg::EXC_SPEC, 8'h00};
  logic i_clk = 1'h0;
  logic i_arst_n = 1'h0;
  wire logic i_ctl_wr, i_fmt_chk, i_seg_chk, i_pte_chk, i_table_dest, i_xlate_req, i_stor_acc, i_stor_write;
  wire logic [15:0] i_inbound_data_bus;
  wire logic [7:0] i_fmt_byte, i_seg_len, o_translation_control_latch, o_exc_code;
  wire logic [31:0] i_seg_entry;
  wire logic [23:0] i_virtual_address_register, i_stor_addr, o_pto, o_pte_addr, o_sar;
  wire logic o_table_reset, o_fmt_1m, o_fmt_4k, o_exc, o_xlate_done, o_hit, o_miss, o_key_upd, o_key_ref, o_key_chg;
  wire logic [12:0] o_key_blk;
  logic e, d, h, m, r, c;
  logic [7:0] ec;
  logic [23:0] sar;
  logic lru_t = 1'h0;
  logic [2:0] lru_i = 3'h0;
  logic [23:0] adj = 24'h000000;
  int num_errors = 0;
  int checks_done = 0;
  dat_tlb dut (.i_clk, .i_arst_n, .i_ctl_wr, .i_inbound_data_bus, .i_fmt_chk, .i_fmt_byte, .i_seg_len, .i_seg_chk,
    .i_seg_entry, .i_pte_chk, .i_table_dest, .i_xlate_req, .i_virtual_address_register, .i_adj_factor(adj),
    .i_lru_touch(lru_t), .i_lru_idx(lru_i), .i_stor_acc, .i_stor_write, .i_stor_addr, .o_translation_control_latch,
    .o_table_reset, .o_fmt_1m, .o_fmt_4k, .o_exc, .o_exc_code, .o_pto, .o_pte_addr, .o_xlate_done, .o_hit,
    .o_miss, .o_sar, .o_key_upd, .o_key_blk, .o_key_ref, .o_key_chg);
  dat_mprog mp (.i_clk, .o_ctl_wr(i_ctl_wr), .o_bus(i_inbound_data_bus), .o_fmt_chk(i_fmt_chk),
    .o_fmt_byte(i_fmt_byte), .o_seg_len(i_seg_len), .o_seg_chk(i_seg_chk), .o_seg_entry(i_seg_entry),
    .o_pte_chk(i_pte_chk), .o_table_dest(i_table_dest), .o_xlate_req(i_xlate_req),
    .o_va(i_virtual_address_register), .o_stor_acc(i_stor_acc), .o_stor_write(i_stor_write),
    .o_stor_addr(i_stor_addr));
  // Clock of 50 ns.
  always #25 i_clk = ~i_clk;
  // Page k of segment 12 hex, its table word and its translated address.
  function automatic logic [23:0] va(input int k);
    return 24'h120456 + 24'(k) * 24'h001000;
  endfunction
  function automatic logic [15:0] pw(input int k);
    return 16'h500F + 16'(k) * 16'h0010;
  endfunction
  function automatic logic [23:0] sa(input int k);
    return 24'h500456 + 24'(k) * 24'h001000;
  endfunction
  task check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Gathers the one-cycle answers over the three cycles after a request.
  task observe();
    e = 1'h0;
    d = 1'h0;
    r = 1'h0;
    c = 1'h0;
    repeat (3) begin
      if (o_exc === 1'h1) begin
        e = 1'h1;
        ec = o_exc_code;
      end
      if (o_xlate_done === 1'h1) begin
        d = 1'h1;
        h = o_hit;
        m = o_miss;
        sar = o_sar;
      end
      r = r | (o_key_ref & o_key_upd);
      c = c | o_key_chg;
      @(negedge i_clk);
    end
  endtask
  task expect_exc(input logic ee, input logic [7:0] code);
    observe();
    check(24'(e), 24'(ee));
    if (ee) check(24'(ec), 24'(code));
  endtask
  task look(input logic [23:0] a, input logic eh, input logic [23:0] es);
    mp.xlate(a);
    observe();
    check(24'(d), 24'h1);
    check(24'({h, m}), 24'({eh, ~eh}));
    if (eh) check(sar, es);
  endtask
  task complete_run();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  // Main sequence of requests and expected answers.
  initial begin
    repeat (16) @(negedge i_clk);
    i_arst_n = 1'h1;
    repeat (3) @(negedge i_clk);
    check(24'(o_translation_control_latch), 24'(dat_pkg::CTL_RESET_VAL));
    for (int k = 0; k < 4; k++) begin
      mp.fmt(FMTS[k], 8'h00);
      expect_exc(1'h0, 8'h00);
      check(24'({o_fmt_1m, o_fmt_4k}), 24'({FMTS[k][dat_pkg::FMT_1M_BIT], FMTS[k][dat_pkg::FMT_4K_BIT]}));
    end
    for (int k = 0; k < 3; k++) begin
      mp.fmt(BADF[k], 8'h00);
      expect_exc(1'h1, dat_pkg::EXC_SPEC);
    end
    mp.fmt(dat_pkg::FMT_1M_4K, 8'h01);
    expect_exc(1'h1, dat_pkg::EXC_SPEC);
    mp.fmt(dat_pkg::FMT_64K_4K, 8'h0F);
    expect_exc(1'h0, 8'h00);
    mp.ctl(8'h80);
    for (int k = 0; k < 8; k++) begin
      look(va(k), 1'h0, 24'h000000);
      mp.dest(va(k), pw(k));
    end
    look(va(0), 1'h1, sa(0));
    mp.dest(va(8), pw(8));
    look(va(1), 1'h0, 24'h000000);
    look(va(8), 1'h1, sa(8));
    look(va(2), 1'h1, sa(2));
    // Microprogram marks entry 3 as used, so the next write lands in entry 4.
    lru_i = 3'h3;
    @(negedge i_clk);
    lru_t = 1'h1;
    @(negedge i_clk);
    lru_t = 1'h0;
    mp.dest(va(10), pw(10));
    look(va(3), 1'h1, sa(3));
    look(va(4), 1'h0, 24'h000000);
    mp.reset_on();
    check(24'(o_table_reset), 24'h1);
    check(24'(o_translation_control_latch), 24'h000081);
    mp.reset_off();
    check(24'(o_table_reset), 24'h0);
    look(va(2), 1'h0, 24'h000000);
    mp.dest(va(9), pw(9));
    look(va(9), 1'h1, sa(9));
    // Emulated access: tag matches unadjusted, displacement comes from the adjusted address.
    adj = 24'h000123;
    mp.ctl(8'hC8);
    look(va(9), 1'h1, sa(9) + 24'h000123);
    mp.ctl(8'h80);
    look(24'h123456, 1'h0, 24'h000000);
    mp.seg(32'hF0123401);
    expect_exc(1'h1, dat_pkg::EXC_SEG);
    mp.seg(32'hF0123408);
    expect_exc(1'h0, 8'h00);
    check(o_pto, 24'h123408);
    check(o_pte_addr, 24'h12340E);
    mp.seg(32'h00123408);
    expect_exc(1'h1, dat_pkg::EXC_PAGE);
    mp.fmt(dat_pkg::FMT_64K_4K, 8'h00);
    expect_exc(1'h0, 8'h00);
    mp.seg(32'hF0123408);
    expect_exc(1'h1, dat_pkg::EXC_SEG);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) mp.fmt(dat_pkg::FMT_64K_2K, 8'h0F);
      if (k == 3) expect_exc(1'h0, 8'h00);
      mp.pte(PTES[k]);
      expect_exc(PEXC[k] != 8'h00, PEXC[k]);
    end
    for (int k = 0; k < 2; k++) begin
      mp.ctl(k == 0 ? 8'h00 : 8'h80);
      if (k == 0) look(24'h654321, 1'h1, 24'h654321);
      mp.acc(24'h654321, k[0]);
      observe();
      check(24'(r), 24'h1);
      check(24'(c), 24'(k[0]));
      check(24'(o_key_blk), 24'h654321 >> 11);
    end
    complete_run();
  end
endmodule
`default_nettype wire
